/* File: src/vcdma_pkg.sv */
// Package of constants for the video capture line burst DMA.
// Assumes a byte-addressed memory and 32-bit capture words.
package vcdma_pkg;
  // Data path widths.
  localparam int DATA_W = 32;
  localparam int WORD_BYTES = 4;
  localparam int ADDR_W = 32;
  localparam int LINE_CNT_W = 12;
  localparam int WORD_CNT_W = 12;
  // Segment size of one full memory burst.
  localparam int SEG_BYTES = 128;
  localparam int SEG_WORDS = SEG_BYTES / WORD_BYTES;
  localparam int SEG_CNT_W = $clog2(SEG_WORDS);
  localparam int LEN_W = $clog2(SEG_BYTES) + 1;
  // Leftover count registers reset to zero.
  localparam logic [LEN_W-1:0] REM_RESET = 8'h00;
  // Components handled by the low capture port.
  localparam int NUM_COMP = 2;
  localparam logic COMP_LUMA = 1'b0;
  localparam logic COMP_CHROMA = 1'b1;
  // Buffer shape.
  localparam int FIFO_DEPTH = 16;
  // Field layout of one buffered word: {sof, eol, comp, data}.
  localparam int FW_DATA_LSB = 0;
  localparam int FW_COMP = DATA_W;
  localparam int FW_EOL = DATA_W + 1;
  localparam int FW_SOF = DATA_W + 2;
  localparam int FW_W = DATA_W + 3;
endpackage : vcdma_pkg

/* File: src/vcdma_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-high reset.
module vcdma_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Filling side.
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Draining side.
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [PTR_W:0] count_reg, count_next;
  logic ready_reg, ready_next;
  logic push, pop;

  // Pointer advance wraps at the configured depth.
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  assign push = i_in_valid && ready_reg;
  assign pop = (count_reg != '0) && i_out_ready;
  assign o_in_ready = ready_reg;
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem[rd_ptr_reg];

  // Next pointers, fill level and registered ready.
  always_comb begin
    wr_ptr_next = push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
    rd_ptr_next = pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
    ready_next = (count_next != DEPTH_CNT);
  end

  // State registers and storage.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
    end
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end
endmodule // vcdma_fifo

/* File: src/vcdma_top.sv */
// Write side of the video capture DMA: limits, chroma line drop, buffer, burst cutter.
// Assumes the capture port and configuration share i_clk; configuration is held stable while capturing.
module vcdma_top (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Configuration and client abort.
  input wire logic i_abort,
  input wire logic i_cfg_chroma_420,
  input wire logic [vcdma_pkg::ADDR_W-1:0] i_cfg_base_luma,
  input wire logic [vcdma_pkg::ADDR_W-1:0] i_cfg_base_chroma,
  input wire logic [vcdma_pkg::ADDR_W-1:0] i_cfg_stride,
  input wire logic [vcdma_pkg::LINE_CNT_W-1:0] i_cfg_max_lines,
  input wire logic [vcdma_pkg::WORD_CNT_W-1:0] i_cfg_max_words,
  // Capture stream from the video input port.
  input wire logic i_cap_valid,
  input wire logic [vcdma_pkg::DATA_W-1:0] i_cap_data,
  input wire logic i_cap_comp,
  input wire logic i_cap_sof,
  input wire logic i_cap_eol,
  output logic o_cap_ready,
  // Memory write stream.
  output logic o_wr_valid,
  output logic [vcdma_pkg::DATA_W-1:0] o_wr_data,
  output logic [vcdma_pkg::ADDR_W-1:0] o_wr_addr,
  output logic [vcdma_pkg::LEN_W-1:0] o_wr_len,
  output logic o_wr_last,
  input wire logic i_wr_ready
);
  localparam int NC = vcdma_pkg::NUM_COMP;
  localparam logic [vcdma_pkg::SEG_CNT_W-1:0] SEG_LAST = vcdma_pkg::SEG_CNT_W'(vcdma_pkg::SEG_WORDS - 1);
  localparam logic [vcdma_pkg::ADDR_W-1:0] SEG_STEP = vcdma_pkg::ADDR_W'(vcdma_pkg::SEG_BYTES);

  // Front-end line and word counters, one set per component.
  logic [vcdma_pkg::LINE_CNT_W-1:0] in_line_reg [NC], in_line_next [NC];
  logic [vcdma_pkg::WORD_CNT_W-1:0] in_word_reg [NC], in_word_next [NC];
  logic [vcdma_pkg::LINE_CNT_W-1:0] cur_line;
  logic [vcdma_pkg::WORD_CNT_W-1:0] cur_word;
  logic cap_fire, keep, force_eol;
  logic [vcdma_pkg::FW_W-1:0] fifo_in;
  logic f_valid, f_pop;
  logic [vcdma_pkg::FW_W-1:0] f_data;

  // Back-end burst state, one set per component.
  logic [vcdma_pkg::ADDR_W-1:0] line_base_reg [NC], line_base_next [NC];
  logic [vcdma_pkg::ADDR_W-1:0] burst_addr_reg [NC], burst_addr_next [NC];
  logic [vcdma_pkg::SEG_CNT_W-1:0] seg_cnt_reg [NC], seg_cnt_next [NC];
  logic ping_reg [NC], ping_next [NC];
  logic [vcdma_pkg::LEN_W-1:0] rem_reg [NC][2], rem_next [NC][2];

  // Output register.
  logic wr_valid_reg, wr_valid_next, wr_last_reg, wr_last_next;
  logic [vcdma_pkg::DATA_W-1:0] wr_data_reg, wr_data_next;
  logic [vcdma_pkg::ADDR_W-1:0] wr_addr_reg, wr_addr_next;
  logic [vcdma_pkg::LEN_W-1:0] wr_len_reg, wr_len_next;

  // Popped word fields.
  logic p_comp, p_sof, p_eol;
  logic [vcdma_pkg::ADDR_W-1:0] p_base, p_addr;
  logic [vcdma_pkg::SEG_CNT_W-1:0] p_seg;

  // Byte count of a burst holding words 0..idx.
  function automatic logic [vcdma_pkg::LEN_W-1:0] seg_bytes(input logic [vcdma_pkg::SEG_CNT_W-1:0] idx);
    seg_bytes = vcdma_pkg::LEN_W'((idx + 1'b1) * vcdma_pkg::WORD_BYTES);
  endfunction

  // Configured start address of a component's frame.
  function automatic logic [vcdma_pkg::ADDR_W-1:0] comp_base(input logic comp);
    comp_base = (comp == vcdma_pkg::COMP_CHROMA) ? i_cfg_base_chroma : i_cfg_base_luma;
  endfunction

  // Front end: a start of frame restarts the counters of its component.
  assign cap_fire = i_cap_valid && o_cap_ready;
  assign cur_line = i_cap_sof ? '0 : in_line_reg[i_cap_comp];
  assign cur_word = i_cap_sof ? '0 : in_word_reg[i_cap_comp];

  // Limits and chroma line drop decide which words enter the buffer.
  always_comb begin
    keep = (cur_line < i_cfg_max_lines) && (cur_word < i_cfg_max_words);
    if (i_cap_comp == vcdma_pkg::COMP_CHROMA && i_cfg_chroma_420 && cur_line[0]) begin
      keep = 1'b0;
    end
    force_eol = (cur_word == i_cfg_max_words - 1'b1);
    fifo_in = '0;
    fifo_in[vcdma_pkg::FW_DATA_LSB +: vcdma_pkg::DATA_W] = i_cap_data;
    fifo_in[vcdma_pkg::FW_COMP] = i_cap_comp;
    fifo_in[vcdma_pkg::FW_EOL] = i_cap_eol || force_eol;
    fifo_in[vcdma_pkg::FW_SOF] = i_cap_sof;
    for (int c = 0; c < NC; c++) begin
      in_line_next[c] = in_line_reg[c];
      in_word_next[c] = in_word_reg[c];
    end
    if (cap_fire) begin
      in_line_next[i_cap_comp] = i_cap_eol ? cur_line + 1'b1 : cur_line;
      in_word_next[i_cap_comp] = i_cap_eol ? '0 : cur_word + 1'b1;
    end
    if (i_abort) begin
      for (int c = 0; c < NC; c++) begin
        in_line_next[c] = '0;
        in_word_next[c] = '0;
      end
    end
  end

  // Front-end counter registers.
  always_ff @(posedge i_clk) begin
    for (int c = 0; c < NC; c++) begin
      if (i_reset) begin
        in_line_reg[c] <= '0;
        in_word_reg[c] <= '0;
      end else begin
        in_line_reg[c] <= in_line_next[c];
        in_word_reg[c] <= in_word_next[c];
      end
    end
  end

  // The buffer between capture and memory; its ready throttles the capture port.
  vcdma_fifo #(
    .WIDTH(vcdma_pkg::FW_W),
    .DEPTH(vcdma_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset || i_abort),
    .i_in_valid(i_cap_valid && keep),
    .i_in_data(fifo_in),
    .o_in_ready(o_cap_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(f_pop)
  );

  // Back end pops a word whenever the output register is free or draining and i_abort is low.
  assign f_pop = f_valid && (!wr_valid_reg || i_wr_ready) && !i_abort;
  assign p_comp = f_data[vcdma_pkg::FW_COMP];
  assign p_sof = f_data[vcdma_pkg::FW_SOF];
  assign p_eol = f_data[vcdma_pkg::FW_EOL];
  assign p_base = p_sof ? comp_base(p_comp) : line_base_reg[p_comp];
  assign p_addr = p_sof ? comp_base(p_comp) : burst_addr_reg[p_comp];
  assign p_seg = p_sof ? '0 : seg_cnt_reg[p_comp];

  // Burst cutting, leftover bookkeeping and address walk.
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      line_base_next[c] = line_base_reg[c];
      burst_addr_next[c] = burst_addr_reg[c];
      seg_cnt_next[c] = seg_cnt_reg[c];
      ping_next[c] = ping_reg[c];
      rem_next[c][0] = rem_reg[c][0];
      rem_next[c][1] = rem_reg[c][1];
    end
    wr_valid_next = wr_valid_reg && !i_wr_ready;
    wr_data_next = wr_data_reg;
    wr_addr_next = wr_addr_reg;
    wr_len_next = wr_len_reg;
    wr_last_next = wr_last_reg;
    if (f_pop) begin
      wr_valid_next = 1'b1;
      wr_data_next = f_data[vcdma_pkg::FW_DATA_LSB +: vcdma_pkg::DATA_W];
      wr_addr_next = p_addr;
      wr_last_next = p_eol || (p_seg == SEG_LAST);
      wr_len_next = vcdma_pkg::LEN_W'(vcdma_pkg::SEG_BYTES);
      line_base_next[p_comp] = p_base;
      burst_addr_next[p_comp] = p_addr;
      seg_cnt_next[p_comp] = p_seg + 1'b1;
      if (p_seg == SEG_LAST && !p_eol) begin
        burst_addr_next[p_comp] = p_addr + SEG_STEP;
        seg_cnt_next[p_comp] = '0;
      end
      if (p_eol) begin
        // Leftover is taken from this very line, so stale or reset values never reach the bus.
        rem_next[p_comp][ping_reg[p_comp]] = seg_bytes(p_seg);
        wr_len_next = seg_bytes(p_seg);
        ping_next[p_comp] = !ping_reg[p_comp];
        line_base_next[p_comp] = p_base + i_cfg_stride;
        burst_addr_next[p_comp] = p_base + i_cfg_stride;
        seg_cnt_next[p_comp] = '0;
      end
    end
    if (i_abort) begin
      wr_valid_next = 1'b0;
      for (int c = 0; c < NC; c++) begin
        line_base_next[c] = comp_base(c[0]);
        burst_addr_next[c] = comp_base(c[0]);
        seg_cnt_next[c] = '0;
        ping_next[c] = 1'b0;
        rem_next[c][0] = vcdma_pkg::REM_RESET;
        rem_next[c][1] = vcdma_pkg::REM_RESET;
      end
    end
  end

  // Back-end registers.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_valid_reg <= 1'b0;
      wr_data_reg <= '0;
      wr_addr_reg <= '0;
      wr_len_reg <= '0;
      wr_last_reg <= 1'b0;
    end else begin
      wr_valid_reg <= wr_valid_next;
      wr_data_reg <= wr_data_next;
      wr_addr_reg <= wr_addr_next;
      wr_len_reg <= wr_len_next;
      wr_last_reg <= wr_last_next;
    end
    for (int c = 0; c < NC; c++) begin
      if (i_reset) begin
        line_base_reg[c] <= '0;
        burst_addr_reg[c] <= '0;
        seg_cnt_reg[c] <= '0;
        ping_reg[c] <= 1'b0;
        rem_reg[c][0] <= vcdma_pkg::REM_RESET;
        rem_reg[c][1] <= vcdma_pkg::REM_RESET;
      end else begin
        line_base_reg[c] <= line_base_next[c];
        burst_addr_reg[c] <= burst_addr_next[c];
        seg_cnt_reg[c] <= seg_cnt_next[c];
        ping_reg[c] <= ping_next[c];
        rem_reg[c][0] <= rem_next[c][0];
        rem_reg[c][1] <= rem_next[c][1];
      end
    end
  end

  // Memory stream outputs come straight from the output register.
  assign o_wr_valid = wr_valid_reg;
  assign o_wr_data = wr_data_reg;
  assign o_wr_addr = wr_addr_reg;
  assign o_wr_len = wr_len_reg;
  assign o_wr_last = wr_last_reg;
endmodule // vcdma_top

/* File: testbench/vcdma_checker.sv */
// Checker of the write stream and reset behaviour of the capture DMA.
// Assumes it is bound to vcdma_top and sees only its ports.
module vcdma_checker (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_reset,
  // Observed ports.
  input wire logic i_abort,
  input wire logic i_wr_ready,
  input wire logic o_cap_ready,
  input wire logic o_wr_valid,
  input wire logic [vcdma_pkg::DATA_W-1:0] o_wr_data,
  input wire logic [vcdma_pkg::ADDR_W-1:0] o_wr_addr,
  input wire logic [vcdma_pkg::LEN_W-1:0] o_wr_len,
  input wire logic o_wr_last
);
  timeunit 1ns;
  timeprecision 1ps;
  // Steps of one memory beat.
  sequence stalled_s;
    o_wr_valid && !i_wr_ready;
  endsequence
  sequence held_s;
    o_wr_valid && $stable(o_wr_data) && $stable(o_wr_addr) && $stable(o_wr_len) && $stable(o_wr_last);
  endsequence
  sequence tail_s;
    o_wr_valid && o_wr_last;
  endsequence
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  beat_hold_a: assert property (disable iff (i_reset || i_abort) stalled_s |=> held_s) else $error("beat changed");
  no_zero_a: assert property (tail_s |-> o_wr_len != 8'h00) else $error("zero burst");
  len_range_a: assert property (o_wr_valid |-> o_wr_len <= 8'h80 && o_wr_len[1:0] == 2'h0) else $error("bad len");
  reset_quiet_a: assert property (disable iff (1'b0) i_reset |=> !o_wr_valid && !o_cap_ready) else $error("busy in reset");
  reset_zero_a: assert property (disable iff (1'b0) i_reset |=> o_wr_len == 8'h00 && !o_wr_last) else $error("len in reset");
  ready_up_a: assert property ($fell(i_reset) |-> ##[0:1] o_cap_ready) else $error("no ready");
  abort_clear_a: assert property (i_abort |=> !o_wr_valid) else $error("valid after abort");
  abort_ready_a: assert property (i_abort |-> ##[1:2] o_cap_ready) else $error("full after abort");
endmodule // vcdma_checker

bind vcdma_top vcdma_checker i_chk (.i_clk(i_clk), .i_reset(i_reset), .i_abort(i_abort), .i_wr_ready(i_wr_ready),
  .o_cap_ready(o_cap_ready), .o_wr_valid(o_wr_valid), .o_wr_data(o_wr_data), .o_wr_addr(o_wr_addr),
  .o_wr_len(o_wr_len), .o_wr_last(o_wr_last));

/* File: testbench/vcdma_mem_model.sv */
// Memory sink standing for the interconnect on the write side.
// Assumes the DMA holds each beat until it is taken.
module vcdma_mem_model (
  // Clock and test controls.
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_hold,
  // Write stream.
  input wire logic i_wr_valid,
  input wire logic [vcdma_pkg::DATA_W-1:0] i_wr_data,
  input wire logic [vcdma_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [vcdma_pkg::LEN_W-1:0] i_wr_len,
  input wire logic i_wr_last,
  output logic o_wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q_data[$];
  logic [31:0] q_addr[$];
  logic [7:0] q_len[$];
  logic q_last[$];
  logic tick_reg = 1'b0;
  // Records every taken beat; slow mode accepts every second cycle.
  always @(posedge i_clk) begin
    tick_reg <= !tick_reg;
    if (i_wr_valid && o_wr_ready) begin
      q_data.push_back(i_wr_data);
      q_addr.push_back(i_wr_addr);
      q_len.push_back(i_wr_len);
      q_last.push_back(i_wr_last);
    end
  end
  assign o_wr_ready = !i_hold && (!i_slow || tick_reg);
endmodule // vcdma_mem_model

/* File: testbench/testbench.sv */
// Self-checking bench of the capture DMA write side.
// Assumes the memory model on the write stream and the bound checker.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BL = 32'h0001_0000;
  localparam logic [31:0] BC = 32'h0002_0000;
  localparam logic [31:0] ST = 32'h0000_0400;
  logic i_clk = 1'b0, i_reset = 1'b1, abort = 1'b0, c420 = 1'b0, slow = 1'b0, hold = 1'b0;
  logic cv = 1'b0, cc = 1'b0, cs = 1'b0, ce = 1'b0;
  logic [31:0] cd = 32'h0;
  logic [11:0] ml = 12'hFFF, mw = 12'hFFF;
  logic ready, wv, wlast, wr;
  logic [31:0] wd, wa;
  logic [7:0] wl;
  int err_total = 0, comparisons = 0, rd = 0;
  vcdma_top i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_abort(abort), .i_cfg_chroma_420(c420),
    .i_cfg_base_luma(BL), .i_cfg_base_chroma(BC), .i_cfg_stride(ST), .i_cfg_max_lines(ml),
    .i_cfg_max_words(mw), .i_cap_valid(cv), .i_cap_data(cd), .i_cap_comp(cc), .i_cap_sof(cs),
    .i_cap_eol(ce), .o_cap_ready(ready), .o_wr_valid(wv), .o_wr_data(wd), .o_wr_addr(wa),
    .o_wr_len(wl), .o_wr_last(wlast), .i_wr_ready(wr));
  vcdma_mem_model i_mem (.i_clk(i_clk), .i_slow(slow), .i_hold(hold), .i_wr_valid(wv), .i_wr_data(wd),
    .i_wr_addr(wa), .i_wr_len(wl), .i_wr_last(wlast), .o_wr_ready(wr));
  // Clock of 8 ns.
  initial begin
    forever #4 i_clk = !i_clk;
  end
  // Compares one value and counts the outcome.
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Sends one line of n words, each held until the buffer takes it.
  task send(input logic c, input int n, input logic s, input logic [31:0] d0);
    for (int k = 0; k < n; k++) begin
      @(negedge i_clk);
      cv = 1'b1;
      cd = d0 + k;
      cc = c;
      cs = s && k == 0;
      ce = k == n - 1;
      while (ready !== 1'b1) @(negedge i_clk);
    end
    @(negedge i_clk);
    cv = 1'b0;
  endtask
  // Checks the beats of one kept line of n words.
  task line(input logic [31:0] base, input int n, input logic [31:0] d0);
    for (int k = 0; k < n; k++) begin
      for (int g = 0; g < 3000 && i_mem.q_addr.size() <= rd; g++) @(negedge i_clk);
      chk("addr", i_mem.q_addr[rd], base + 128 * (k / 32));
      chk("data", i_mem.q_data[rd], d0 + k);
      chk("last", i_mem.q_last[rd], k % 32 == 31 || k == n - 1);
      if (k == n - 1) chk("len", i_mem.q_len[rd], ((n - 1) % 32 + 1) * 4);
      else if (k % 32 == 31) chk("len", i_mem.q_len[rd], 128);
      rd++;
    end
  endtask
  // One-line frames right after reset, single channel only.
  task t_first();
    send(0, 1, 1, 32'h100);
    line(BL, 1, 32'h100);
    send(0, 3, 1, 32'h200);
    line(BL, 3, 32'h200);
    $display("test first_frames done");
  endtask
  // Long line with a slow memory, then a short line.
  task t_long();
    slow = 1'b1;
    send(0, 33, 1, 32'h300);
    send(0, 2, 0, 32'h400);
    line(BL, 33, 32'h300);
    line(BL + ST, 2, 32'h400);
    slow = 1'b0;
    send(0, 32, 1, 32'h500);
    send(0, 1, 0, 32'h600);
    line(BL, 32, 32'h500);
    line(BL + ST, 1, 32'h600);
    $display("test long_lines done");
  endtask
  // Chroma 420 drop with luma in between.
  task t_chroma();
    c420 = 1'b1;
    send(1, 2, 1, 32'h700);
    send(1, 2, 0, 32'h800);
    send(0, 1, 1, 32'h900);
    send(1, 3, 1, 32'hA00);
    line(BC, 2, 32'h700);
    line(BL, 1, 32'h900);
    line(BC, 3, 32'hA00);
    c420 = 1'b0;
    $display("test chroma_420 done");
  endtask
  // Line and width limits.
  task t_limit();
    mw = 12'h004;
    ml = 12'h002;
    send(0, 6, 1, 32'hB00);
    send(0, 6, 0, 32'hC00);
    send(0, 6, 0, 32'hD00);
    line(BL, 4, 32'hB00);
    line(BL + ST, 4, 32'hC00);
    repeat (40) @(negedge i_clk);
    chk("count", i_mem.q_addr.size(), rd);
    mw = 12'hFFF;
    ml = 12'hFFF;
    $display("test limits done");
  endtask
  // Fills the buffer with memory stalled, then drains it.
  task t_fill();
    hold = 1'b1;
    fork
      send(0, 24, 1, 32'hE00);
      begin
        repeat (60) @(negedge i_clk);
        chk("ready", ready, 1'b0);
        hold = 1'b0;
      end
    join
    line(BL, 24, 32'hE00);
    $display("test fill done");
  endtask
  // Abort drops pending words; two one-line frames follow.
  task t_abort();
    hold = 1'b1;
    send(0, 3, 1, 32'hF00);
    abort = 1'b1;
    @(negedge i_clk);
    abort = 1'b0;
    hold = 1'b0;
    repeat (20) @(negedge i_clk);
    chk("count", i_mem.q_addr.size(), rd);
    send(0, 1, 1, 32'h1000);
    line(BL, 1, 32'h1000);
    send(0, 1, 1, 32'h1100);
    line(BL, 1, 32'h1100);
    $display("test abort done");
  endtask
  // Prints the counts and the verdict, then ends the run.
  task stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (16) @(negedge i_clk);
    i_reset = 1'b0;
    t_first();
    t_long();
    t_chroma();
    t_limit();
    t_fill();
    t_abort();
    stop_test();
  end
  // Watchdog far beyond the expected run.
  initial begin
    repeat (30000) @(posedge i_clk);
    err_total++;
    stop_test();
  end
endmodule // testbench
